// *** src/usb_fifo_pkg.sv ***
// Constants, types and register map of the shared FIFO RAM partition block
package usb_fifo_pkg;

  // ------------------------------------------------------------
  // Register byte offsets on the Wishbone slave
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_RX_SIZE = 8'h00;
  localparam logic [7:0] OFF_NP_SIZE = 8'h04;
  localparam logic [7:0] OFF_P_SIZE = 8'h08;
  localparam logic [7:0] OFF_RST_CTL = 8'h0C;
  localparam logic [7:0] OFF_CFG = 8'h10;
  localparam logic [7:0] OFF_LEVEL = 8'h14;
  localparam logic [7:0] OFF_RX_POP = 8'h18;
  localparam logic [7:0] OFF_TX_PUSH = 8'h1C;
  localparam logic [7:0] OFF_INEP_BASE = 8'h20;
  localparam logic [7:0] OFF_DMA_BASE = 8'h40;

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int DEPTH_LSB = 16;
  localparam int START_LSB = 0;
  localparam int RXF_BIT = 4;
  localparam int TXF_BIT = 5;
  localparam int TXSEL_LSB = 6;
  localparam int CFG_HOST_BIT = 0;
  localparam int CFG_DMA_BIT = 1;
  localparam int CFG_PSEL_LSB = 2;
  localparam logic [4:0] TX_FLUSH_ALL = 5'h10;
  localparam logic [31:0] REG_RST = 32'h0000_0000;

  // ------------------------------------------------------------
  // Entry kinds that the core writes into the receive FIFO
  // ------------------------------------------------------------
  localparam logic [3:0] KIND_STATUS = 4'h1;
  localparam logic [3:0] KIND_DONE = 4'h2;
  localparam logic [3:0] KIND_HALT = 4'h3;
  localparam logic [3:0] KIND_REWIND = 4'h4;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int FLUSH_TIME_NS = 64;
  localparam int FLUSH_CYC = (FLUSH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {FL_IDLE = 2'b01, FL_BUSY = 2'b10} flush_state_e;
  typedef enum logic [2:0] {RG_IDLE = 3'b001, RG_STATUS = 3'b010, RG_HALT = 3'b100} rx_gen_e;

  typedef struct packed {
    logic valid;
    logic last;
    logic [31:0] data;
  } rx_word_s;

  typedef struct packed {
    logic valid;
    logic rewind;
    logic [3:0] num;
  } rx_event_s;

  typedef struct packed {
    logic req;
    logic [1:0] sel;
  } tx_pop_s;

endpackage

// *** src/usb_fifo_ram_partition.sv ***
// Shared data FIFO RAM split into one receive FIFO and several transmit FIFOs
//
// Summary of operation
// - Flush all FIFOs; core resets pointers
// - Flush bits self-clear; software waits for them
// - Core writes status word with each packet
// - Final packet adds complete and halted entries
// - Core stores NAK rewind entries in receive FIFO
// - Channel DMA addresses live in FIFO RAM
// - One receive region; host and device share
// - Device DMA keeps one word per endpoint direction
// - DMA address words sit at RAM top
//
// Implementation choices: the address map and register access over Wishbone.
module usb_fifo_ram_partition #(
  parameter int RAM_DEPTH = 256,
  parameter int NUM_TX = 4,
  parameter int DMA_SLOTS = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack,
  input wire usb_fifo_pkg::rx_word_s rx_in,
  output logic rx_ack,
  input wire usb_fifo_pkg::rx_event_s rx_evt,
  output logic evt_ack,
  input wire usb_fifo_pkg::tx_pop_s tx_pop,
  output logic tx_pop_ack,
  output logic [31:0] tx_pop_data
);
  import usb_fifo_pkg::*;

  localparam int AW = $clog2(RAM_DEPTH);
  localparam int FL_WAIT = FLUSH_CYC + 1;
  localparam logic [7:0] FL_LOAD = 8'(FLUSH_CYC - 1);

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  if (RAM_DEPTH < 16 || RAM_DEPTH > 32768 || (1 << AW) != RAM_DEPTH) begin : g_bad_depth
    $error("RAM_DEPTH must be a power of two from 16 to 32768");
  end
  if (NUM_TX < 2 || NUM_TX > 4 || DMA_SLOTS < 1 || DMA_SLOTS > 48) begin : g_bad_count
    $error("NUM_TX must be 2..4 and DMA_SLOTS 1..48");
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Offset wraps at the programmed depth, never beyond it
  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p, input logic [AW:0] d);
    ptr_inc = (({1'b0, p} + (AW+1)'(1)) >= d) ? '0 : p + 1'b1;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    merge = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        merge[8*b +: 8] = n[8*b +: 8];
      end
    end
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [31:0] receive_fifo_size_reg, nonperiodic_tx_fifo_size_reg;
  logic [31:0] host_periodic_tx_fifo_size_reg, cfg;
  logic [31:0] in_endpoint_tx_fifo_size_reg [1:NUM_TX-1];
  logic rx_fifo_flush, tx_fifo_flush;
  logic [4:0] tx_fifo_flush_select;
  flush_state_e fstate;
  logic [7:0] fcnt;
  logic [31:0] ram [RAM_DEPTH];
  logic [AW-1:0] rx_wr, rx_rd;
  logic [AW:0] rx_lvl;
  logic [AW-1:0] tx_wr [NUM_TX];
  logic [AW-1:0] tx_rd [NUM_TX];
  logic [AW:0] tx_lvl [NUM_TX];
  rx_gen_e rg_state;
  logic [15:0] pkt_words;
  logic [3:0] evt_num;

  logic [31:0] next_receive_fifo_size_reg, next_nonperiodic_tx_fifo_size_reg;
  logic [31:0] next_host_periodic_tx_fifo_size_reg, next_cfg;
  logic [31:0] next_in_endpoint_tx_fifo_size_reg [1:NUM_TX-1];
  logic next_rx_fifo_flush, next_tx_fifo_flush;
  logic [4:0] next_tx_fifo_flush_select;
  flush_state_e next_fstate;
  logic [7:0] next_fcnt;
  logic [31:0] next_ram [RAM_DEPTH];
  logic [AW-1:0] next_rx_wr, next_rx_rd;
  logic [AW:0] next_rx_lvl;
  logic [AW-1:0] next_tx_wr [NUM_TX];
  logic [AW-1:0] next_tx_rd [NUM_TX];
  logic [AW:0] next_tx_lvl [NUM_TX];
  rx_gen_e next_rg_state;
  logic [15:0] next_pkt_words;
  logic [3:0] next_evt_num;
  logic [31:0] next_wb_dat_o, next_tx_pop_data;
  logic next_wb_ack, next_rx_ack, next_evt_ack, next_tx_pop_ack;

  // Region map derived from the size registers
  logic [AW-1:0] tx_start [NUM_TX];
  logic [AW:0] tx_depth [NUM_TX];
  logic [AW:0] rx_depth;
  logic host_mode, dma_mode;

  // ------------------------------------------------------------
  // Region map
  // ------------------------------------------------------------
  // Receive FIFO sits at word 0 in both roles; transmit regions share one space
  always_comb begin
    host_mode = cfg[CFG_HOST_BIT];
    dma_mode = cfg[CFG_DMA_BIT];
    rx_depth = receive_fifo_size_reg[START_LSB +: AW+1];
    for (int i = 0; i < NUM_TX; i++) begin
      if (i == 0) begin
        tx_start[i] = nonperiodic_tx_fifo_size_reg[START_LSB +: AW];
        tx_depth[i] = nonperiodic_tx_fifo_size_reg[DEPTH_LSB +: AW+1];
      end else if (i == 1 && host_mode) begin
        tx_start[i] = host_periodic_tx_fifo_size_reg[START_LSB +: AW];
        tx_depth[i] = host_periodic_tx_fifo_size_reg[DEPTH_LSB +: AW+1];
      end else begin
        tx_start[i] = in_endpoint_tx_fifo_size_reg[i][START_LSB +: AW];
        tx_depth[i] = in_endpoint_tx_fifo_size_reg[i][DEPTH_LSB +: AW+1];
      end
    end
  end

  // ------------------------------------------------------------
  // Next state: bus slave, flush, receive writer, transmit reader
  // ------------------------------------------------------------
  // One process, because the bus, the flush and both FIFO sides share the RAM
  always_comb begin
    logic rx_we;
    logic [31:0] rx_word;
    logic rx_pop;
    logic [1:0] psel;
    logic [7:0] rel;
    int idx;
    rx_we = 1'b0;
    rx_word = '0;
    rx_pop = 1'b0;
    psel = cfg[CFG_PSEL_LSB +: 2];
    rel = '0;
    idx = 0;
    next_receive_fifo_size_reg = receive_fifo_size_reg;
    next_nonperiodic_tx_fifo_size_reg = nonperiodic_tx_fifo_size_reg;
    next_host_periodic_tx_fifo_size_reg = host_periodic_tx_fifo_size_reg;
    next_in_endpoint_tx_fifo_size_reg = in_endpoint_tx_fifo_size_reg;
    next_cfg = cfg;
    next_rx_fifo_flush = rx_fifo_flush;
    next_tx_fifo_flush = tx_fifo_flush;
    next_tx_fifo_flush_select = tx_fifo_flush_select;
    next_fstate = fstate;
    next_fcnt = fcnt;
    next_ram = ram;
    next_rx_wr = rx_wr;
    next_rx_rd = rx_rd;
    next_rx_lvl = rx_lvl;
    next_tx_wr = tx_wr;
    next_tx_rd = tx_rd;
    next_tx_lvl = tx_lvl;
    next_rg_state = rg_state;
    next_pkt_words = pkt_words;
    next_evt_num = evt_num;
    next_wb_ack = 1'b0;
    next_wb_dat_o = '0;
    next_rx_ack = 1'b0;
    next_evt_ack = 1'b0;
    next_tx_pop_ack = 1'b0;
    next_tx_pop_data = tx_pop_data;

    // Classic slave: ack one cycle after the strobe, unmapped reads give zero
    if (wb_cyc && wb_stb && !wb_ack) begin
      next_wb_ack = 1'b1;
      if (wb_adr >= OFF_DMA_BASE) begin
        rel = wb_adr - OFF_DMA_BASE;
        idx = int'(rel[7:2]);
        // Slots count down from the last word, above every FIFO region
        if (dma_mode && idx < DMA_SLOTS) begin
          if (wb_we) begin
            next_ram[RAM_DEPTH-1-idx] = merge(ram[RAM_DEPTH-1-idx], wb_dat_i, wb_sel);
          end else begin
            next_wb_dat_o = ram[RAM_DEPTH-1-idx];
          end
        end
      end else if (wb_adr >= OFF_INEP_BASE + 8'h04) begin
        rel = wb_adr - OFF_INEP_BASE;
        idx = int'(rel[7:2]);
        if (idx < NUM_TX) begin
          if (wb_we) begin
            next_in_endpoint_tx_fifo_size_reg[idx] =
              merge(in_endpoint_tx_fifo_size_reg[idx], wb_dat_i, wb_sel);
          end else begin
            next_wb_dat_o = in_endpoint_tx_fifo_size_reg[idx];
          end
        end
      end else begin
        case (wb_adr)
          OFF_RX_SIZE: begin
            if (wb_we) next_receive_fifo_size_reg = merge(receive_fifo_size_reg, wb_dat_i, wb_sel);
            else next_wb_dat_o = receive_fifo_size_reg;
          end
          OFF_NP_SIZE: begin
            if (wb_we) begin
              next_nonperiodic_tx_fifo_size_reg =
                merge(nonperiodic_tx_fifo_size_reg, wb_dat_i, wb_sel);
            end else begin
              next_wb_dat_o = nonperiodic_tx_fifo_size_reg;
            end
          end
          OFF_P_SIZE: begin
            if (wb_we) begin
              next_host_periodic_tx_fifo_size_reg =
                merge(host_periodic_tx_fifo_size_reg, wb_dat_i, wb_sel);
            end else begin
              next_wb_dat_o = host_periodic_tx_fifo_size_reg;
            end
          end
          OFF_RST_CTL: begin
            // Flush bits only arm while idle; a busy flush ignores new writes
            if (wb_we && fstate == FL_IDLE && wb_sel[0]
                && (wb_dat_i[RXF_BIT] || wb_dat_i[TXF_BIT])) begin
              next_rx_fifo_flush = wb_dat_i[RXF_BIT];
              next_tx_fifo_flush = wb_dat_i[TXF_BIT];
              next_tx_fifo_flush_select = wb_dat_i[TXSEL_LSB +: 5];
              next_fcnt = FL_LOAD;
              next_fstate = FL_BUSY;
            end else if (!wb_we) begin
              next_wb_dat_o[RXF_BIT] = rx_fifo_flush;
              next_wb_dat_o[TXF_BIT] = tx_fifo_flush;
              next_wb_dat_o[TXSEL_LSB +: 5] = tx_fifo_flush_select;
            end
          end
          OFF_CFG: begin
            if (wb_we) next_cfg = merge(cfg, wb_dat_i, wb_sel) & 32'h0000_000F;
            else next_wb_dat_o = cfg;
          end
          OFF_LEVEL: begin
            if (!wb_we) next_wb_dat_o = {16'(tx_lvl[psel]), 16'(rx_lvl)};
          end
          OFF_RX_POP: begin
            // Reading pops one word; an empty FIFO reads zero and stays put
            if (!wb_we && rx_lvl != '0) begin
              next_wb_dat_o = ram[rx_rd];
              next_rx_rd = ptr_inc(rx_rd, rx_depth);
              rx_pop = 1'b1;
            end
          end
          OFF_TX_PUSH: begin
            // A push into a full FIFO is dropped rather than stalling the bus
            if (wb_we && 32'(psel) < NUM_TX && tx_lvl[psel] < tx_depth[psel]) begin
              next_ram[tx_start[psel] + tx_wr[psel]] = wb_dat_i;
              next_tx_wr[psel] = ptr_inc(tx_wr[psel], tx_depth[psel]);
              next_tx_lvl[psel] = next_tx_lvl[psel] + 1'b1;
            end
          end
          default: begin
            next_wb_dat_o = '0;
          end
        endcase
      end
    end

    // USB side reads one transmit word per request, waiting while empty
    if (tx_pop.req && !tx_pop_ack && 32'(tx_pop.sel) < NUM_TX && tx_lvl[tx_pop.sel] != '0) begin
      next_tx_pop_data = ram[tx_start[tx_pop.sel] + tx_rd[tx_pop.sel]];
      next_tx_rd[tx_pop.sel] = ptr_inc(tx_rd[tx_pop.sel], tx_depth[tx_pop.sel]);
      next_tx_lvl[tx_pop.sel] = next_tx_lvl[tx_pop.sel] - 1'b1;
      next_tx_pop_ack = 1'b1;
    end

    // Receive writer; held off during a receive flush and when full
    if (!(fstate == FL_BUSY && rx_fifo_flush) && rx_lvl < rx_depth) begin
      case (rg_state)
        RG_IDLE: begin
          if (rx_evt.valid && !evt_ack) begin
            rx_we = 1'b1;
            next_evt_ack = 1'b1;
            next_evt_num = rx_evt.num;
            if (rx_evt.rewind) begin
              rx_word = {KIND_REWIND, 24'h0, rx_evt.num};
            end else begin
              rx_word = {KIND_DONE, 24'h0, rx_evt.num};
              next_rg_state = RG_HALT;
            end
          end else if (rx_in.valid && !rx_ack) begin
            rx_we = 1'b1;
            rx_word = rx_in.data;
            next_rx_ack = 1'b1;
            next_pkt_words = pkt_words + 1'b1;
            if (rx_in.last) next_rg_state = RG_STATUS;
          end
        end
        RG_STATUS: begin
          rx_we = 1'b1;
          rx_word = {KIND_STATUS, 12'h0, pkt_words};
          next_pkt_words = '0;
          next_rg_state = RG_IDLE;
        end
        RG_HALT: begin
          rx_we = 1'b1;
          rx_word = {KIND_HALT, 24'h0, evt_num};
          next_rg_state = RG_IDLE;
        end
        default: begin
          next_rg_state = RG_IDLE;
        end
      endcase
    end
    if (rx_we) begin
      next_ram[rx_wr] = rx_word;
      next_rx_wr = ptr_inc(rx_wr, rx_depth);
    end
    next_rx_lvl = rx_lvl + (AW+1)'(rx_we) - (AW+1)'(rx_pop);

    // Flush countdown; at completion pointers reset and bits self-clear in the same cycle
    case (fstate)
      FL_IDLE: begin
      end
      FL_BUSY: begin
        if (fcnt == '0) begin
          if (rx_fifo_flush) begin
            next_rx_wr = '0;
            next_rx_rd = '0;
            next_rx_lvl = '0;
            next_rg_state = RG_IDLE;
            next_pkt_words = '0;
          end
          for (int i = 0; i < NUM_TX; i++) begin
            if (tx_fifo_flush && (tx_fifo_flush_select == TX_FLUSH_ALL
                || tx_fifo_flush_select == 5'(i))) begin
              next_tx_wr[i] = '0;
              next_tx_rd[i] = '0;
              next_tx_lvl[i] = '0;
            end
          end
          next_rx_fifo_flush = 1'b0;
          next_tx_fifo_flush = 1'b0;
          next_fstate = FL_IDLE;
        end else begin
          next_fcnt = fcnt - 1'b1;
        end
      end
      default: begin
        next_fstate = FL_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  // RAM contents carry no reset; software allocates before any traffic
  always_ff @(posedge clk) begin
    ram <= next_ram;
    if (!rst_n) begin
      receive_fifo_size_reg <= REG_RST;
      nonperiodic_tx_fifo_size_reg <= REG_RST;
      host_periodic_tx_fifo_size_reg <= REG_RST;
      in_endpoint_tx_fifo_size_reg <= '{default: REG_RST};
      cfg <= REG_RST;
      rx_fifo_flush <= 1'b0;
      tx_fifo_flush <= 1'b0;
      tx_fifo_flush_select <= '0;
      fstate <= FL_IDLE;
      fcnt <= '0;
      rx_wr <= '0;
      rx_rd <= '0;
      rx_lvl <= '0;
      tx_wr <= '{default: '0};
      tx_rd <= '{default: '0};
      tx_lvl <= '{default: '0};
      rg_state <= RG_IDLE;
      pkt_words <= '0;
      evt_num <= '0;
      wb_ack <= 1'b0;
      wb_dat_o <= '0;
      rx_ack <= 1'b0;
      evt_ack <= 1'b0;
      tx_pop_ack <= 1'b0;
      tx_pop_data <= '0;
    end else begin
      receive_fifo_size_reg <= next_receive_fifo_size_reg;
      nonperiodic_tx_fifo_size_reg <= next_nonperiodic_tx_fifo_size_reg;
      host_periodic_tx_fifo_size_reg <= next_host_periodic_tx_fifo_size_reg;
      in_endpoint_tx_fifo_size_reg <= next_in_endpoint_tx_fifo_size_reg;
      cfg <= next_cfg;
      rx_fifo_flush <= next_rx_fifo_flush;
      tx_fifo_flush <= next_tx_fifo_flush;
      tx_fifo_flush_select <= next_tx_fifo_flush_select;
      fstate <= next_fstate;
      fcnt <= next_fcnt;
      rx_wr <= next_rx_wr;
      rx_rd <= next_rx_rd;
      rx_lvl <= next_rx_lvl;
      tx_wr <= next_tx_wr;
      tx_rd <= next_tx_rd;
      tx_lvl <= next_tx_lvl;
      rg_state <= next_rg_state;
      pkt_words <= next_pkt_words;
      evt_num <= next_evt_num;
      wb_ack <= next_wb_ack;
      wb_dat_o <= next_wb_dat_o;
      rx_ack <= next_rx_ack;
      evt_ack <= next_evt_ack;
      tx_pop_ack <= next_tx_pop_ack;
      tx_pop_data <= next_tx_pop_data;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_flush_self_clear: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(fstate == FL_BUSY) |-> ##[1:FL_WAIT] (!rx_fifo_flush && !tx_fifo_flush))
    else $error("flush bit did not self-clear in time");
  a_flush_rx_reset: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(rx_fifo_flush) |-> (rx_lvl == '0 && rx_wr == '0 && rx_rd == '0))
    else $error("receive pointers not reset by flush");
  a_status_after_pkt: assert property (@(posedge clk) disable iff (!rst_n)
    (rx_ack && rg_state == RG_STATUS) |-> (pkt_words != '0))
    else $error("status pending with no packet words");
  a_halt_after_done: assert property (@(posedge clk) disable iff (!rst_n)
    (rg_state == RG_HALT && rx_lvl < rx_depth && fstate == FL_IDLE)
      |=> (rg_state == RG_IDLE && ram[$past(rx_wr)][31:28] == KIND_HALT))
    else $error("halted entry missing after complete entry");
  a_rx_in_bounds: assert property (@(posedge clk) disable iff (!rst_n)
    (rx_lvl <= rx_depth) || $changed(receive_fifo_size_reg))
    else $error("receive level beyond programmed depth");
  a_tx_in_bounds: assert property (@(posedge clk) disable iff (!rst_n)
    (tx_lvl[0] <= tx_depth[0]) || $changed(nonperiodic_tx_fifo_size_reg))
    else $error("transmit level beyond programmed depth");
  a_dma_at_top: assert property (@(posedge clk) disable iff (!rst_n)
    (wb_cyc && wb_stb && wb_we && !wb_ack && dma_mode && wb_adr == OFF_DMA_BASE
      && wb_sel == 4'hF) |=> (ram[RAM_DEPTH-1] == $past(wb_dat_i)))
    else $error("DMA address word not at top of RAM");
  a_ack_single: assert property (@(posedge clk) disable iff (!rst_n)
    (wb_cyc && wb_stb && !wb_ack) |=> wb_ack ##1 !wb_ack)
    else $error("bus ack not a single cycle");
endmodule

// *** testbench/usb_side_model.sv ***
// USB-side partner model: receive words, channel events and transmit pops
module usb_side_model (
  input wire logic clk,
  output usb_fifo_pkg::rx_word_s rx_in,
  input wire logic rx_ack,
  output usb_fifo_pkg::rx_event_s rx_evt,
  input wire logic evt_ack,
  output usb_fifo_pkg::tx_pop_s tx_pop,
  input wire logic tx_pop_ack,
  input wire logic [31:0] tx_pop_data
);
  timeunit 1ns;
  timeprecision 1ps;
  import usb_fifo_pkg::*;
  logic [2:0] acks;
  assign acks = {tx_pop_ack, evt_ack, rx_ack};
  // --------------------------------
  // Idle lines and handshake wait
  // --------------------------------
  initial begin
    rx_in = '0;
    rx_evt = '0;
    tx_pop = '0;
  end
  // No cycle limit here; the bench watchdog ends a handshake that never completes
  task automatic await(input int k);
    @(posedge clk);
    while (acks[k] !== 1'b1) begin
      @(posedge clk);
    end
  endtask
  // Released fields flip, except last, which drops to 0, so stale values never look valid
  task automatic send_word(input logic [31:0] d, input logic last);
    @(posedge clk);
    rx_in <= '{1'b1, last, d};
    await(0);
    rx_in <= '{1'b0, 1'b0, ~d};
  endtask
  task automatic send_evt(input logic rw, input logic [3:0] num);
    @(posedge clk);
    rx_evt <= '{1'b1, rw, num};
    await(1);
    rx_evt <= '{1'b0, ~rw, ~num};
  endtask
  task automatic pop(input logic [1:0] s, output logic [31:0] d);
    @(posedge clk);
    tx_pop <= '{1'b1, s};
    await(2);
    d = tx_pop_data;
    tx_pop <= '{1'b0, ~s};
  endtask
endmodule

// *** testbench/test_usb_fifo_ram_partition.sv ***
// Self-checking bench for the shared FIFO RAM partition block
module test_usb_fifo_ram_partition;
  timeunit 1ns;
  timeprecision 1ps;
  import usb_fifo_pkg::*;
  logic clk, rst_n, cyc, stb, we, wb_ack, rx_ack, evt_ack, tx_pop_ack;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_w, wb_dat_o, tx_pop_data, q, d;
  rx_word_s rx_in;
  rx_event_s rx_evt;
  tx_pop_s tx_pop;
  int err_total, checks;
  usb_fifo_ram_partition u_usb_fifo_ram_partition (.clk(clk), .rst_n(rst_n), .wb_cyc(cyc),
    .wb_stb(stb), .wb_we(we), .wb_adr(adr), .wb_sel(sel), .wb_dat_i(dat_w),
    .wb_dat_o(wb_dat_o), .wb_ack(wb_ack), .rx_in(rx_in), .rx_ack(rx_ack), .rx_evt(rx_evt),
    .evt_ack(evt_ack), .tx_pop(tx_pop), .tx_pop_ack(tx_pop_ack), .tx_pop_data(tx_pop_data));
  usb_side_model u_usb_side_model (.clk(clk), .rx_in(rx_in), .rx_ack(rx_ack), .rx_evt(rx_evt),
    .evt_ack(evt_ack), .tx_pop(tx_pop), .tx_pop_ack(tx_pop_ack), .tx_pop_data(tx_pop_data));
  // --------------------------------
  // Clock, compare and bus helpers
  // --------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      $display("ERROR %0t: got %h exp %h", $time, got, exp);
      err_total++;
    end
  endtask
  // Classic cycle: request held until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= v;
    @(posedge clk);
    while (wb_ack !== 1'b1) begin
      @(posedge clk);
    end
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic t_alloc;
    wb(1'b1, 8'h3C, 32'hFFFF_FFFF);
    rdc(8'h3C, 32'h0);
    wb(1'b1, OFF_CFG, 32'h1);
    wb(1'b1, OFF_RX_SIZE, 32'h0000_0010);
    wb(1'b1, OFF_NP_SIZE, 32'h0008_0010);
    wb(1'b1, OFF_P_SIZE, 32'h0008_0018);
    rdc(OFF_P_SIZE, 32'h0008_0018);
    u_usb_side_model.send_word(32'hDEAD_0001, 1'b0);
    rdc(OFF_LEVEL, 32'h1);
    wb(1'b1, OFF_RST_CTL, {21'h0, TX_FLUSH_ALL, 2'b11, 4'h0});
    wb(1'b0, OFF_RST_CTL, 32'h0);
    chk(q & 32'h30, 32'h30);
    repeat (20) if ((q & 32'h30) != 32'h0) wb(1'b0, OFF_RST_CTL, 32'h0);
    chk(q & 32'h30, 32'h0);
    rdc(OFF_LEVEL, 32'h0);
    $display("test alloc done");
  endtask
  task automatic t_rx;
    u_usb_side_model.send_word(32'h0000_1111, 1'b0);
    u_usb_side_model.send_word(32'h0000_2222, 1'b1);
    rdc(OFF_LEVEL, 32'h3);
    rdc(OFF_RX_POP, 32'h0000_1111);
    rdc(OFF_RX_POP, 32'h0000_2222);
    rdc(OFF_RX_POP, 32'h1000_0002);
    u_usb_side_model.send_evt(1'b0, 4'h5);
    u_usb_side_model.send_evt(1'b1, 4'h3);
    rdc(OFF_RX_POP, 32'h2000_0005);
    rdc(OFF_RX_POP, 32'h3000_0005);
    rdc(OFF_RX_POP, 32'h4000_0003);
    rdc(OFF_RX_POP, 32'h0);
    $display("test receive done");
  endtask
  task automatic t_tx_dma;
    wb(1'b1, OFF_CFG, 32'h5);
    wb(1'b1, OFF_TX_PUSH, 32'hA5A5_0001);
    wb(1'b1, OFF_TX_PUSH, 32'h5A5A_0002);
    rdc(OFF_LEVEL, 32'h0002_0000);
    u_usb_side_model.pop(2'h1, d);
    chk(d, 32'hA5A5_0001);
    u_usb_side_model.pop(2'h1, d);
    chk(d, 32'h5A5A_0002);
    wb(1'b1, OFF_CFG, 32'h7);
    wb(1'b1, OFF_DMA_BASE, 32'h1234_5678);
    wb(1'b1, 8'h5C, 32'h0BAD_F00D);
    rdc(OFF_DMA_BASE, 32'h1234_5678);
    rdc(8'h5C, 32'h0BAD_F00D);
    wb(1'b1, OFF_CFG, 32'h5);
    rdc(OFF_DMA_BASE, 32'h0);
    $display("test transmit and dma done");
  endtask
  // Device role: FIFO 1 comes from the first IN endpoint register, depth 4 this time
  task automatic t_device;
    wb(1'b1, OFF_CFG, 32'h4);
    wb(1'b1, 8'h24, 32'h0004_0018);
    rdc(8'h24, 32'h0004_0018);
    wb(1'b1, OFF_RST_CTL, {21'h0, 5'h01, 2'b10, 4'h0});
    wb(1'b0, OFF_RST_CTL, 32'h0);
    chk(q & 32'h7F0, 32'h060);
    repeat (20) if ((q & 32'h30) != 32'h0) wb(1'b0, OFF_RST_CTL, 32'h0);
    chk(q & 32'h30, 32'h0);
    // Five pushes into a depth of four: the last one must be dropped
    for (int i = 0; i < 5; i++) wb(1'b1, OFF_TX_PUSH, 32'hC3C3_0000 + 32'(i));
    rdc(OFF_LEVEL, 32'h0004_0000);
    u_usb_side_model.pop(2'h1, d);
    chk(d, 32'hC3C3_0000);
    $display("test device done");
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Main sequence; reset held for 12 cycles
  initial begin
    {rst_n, cyc, stb, we, adr, dat_w, err_total, checks} = '0;
    sel = 4'hF;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_alloc();
    t_rx();
    t_tx_dma();
    t_device();
    print_verdict();
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    print_verdict();
  end
endmodule
